// >>> pkg/lcmc_defs.vh
`ifndef LCMC_DEFS_VH
`define LCMC_DEFS_VH

// clock rate
`define LCMC_CLK_HZ 25000000
// low-power entry hold, in clock cycles
`define LCMC_ENTRY_HOLD_CYC 22'h000005
// remote wake dominant time, in microseconds
`define LCMC_WAKE_US 100
// 100 us at 25 MHz, sized to the counter width
`define LCMC_WAKE_CYC 22'h0009c4
// temporary shutdown interval, in milliseconds
`define LCMC_TSHD_MS 128
// 128 ms at 25 MHz, sized to the counter width
`define LCMC_TSHD_CYC 22'h30d400
`define LCMC_CNT_W 22

// mode codes
`define LCMC_ST_OFF 3'h0
`define LCMC_ST_NORMAL 3'h1
`define LCMC_ST_STANDBY 3'h2
`define LCMC_ST_SLEEP 3'h3
`define LCMC_ST_TMPSD 3'h4
`define LCMC_ST_THERM 3'h5

`endif

// >>> rtl/lcmc_mode_ctrl.v
`timescale 1ns/1ps
`include "lcmc_defs.vh"
// What this block does
// - after power-up enter normal mode with all blocks but wake detection enabled
// - normal mode passes transmit data to the bus driver
// - temperature above warning level sets sticky heat warning flag
// - standby disables transceiver, watchdogs, divider, relays; wake and thermal on
// - factory strap selects standby or sleep as the low-power state
// - sleep switches off regulator, transceiver, reset unit and watchdog
// - sleep returns to normal only on remote wake: bus dominant for the wake time
// - temporary shutdown only usable when its factory option is set
// - temporary shutdown keeps only oscillator and registers; bus recessive
// - temporary shutdown pulls select, receive, transmit low; no remote wake
// - temporary shutdown returns to normal after the 128 ms counter
// - software control bit moves normal or standby into temporary shutdown
// - overheat from any mode but off enters thermal shutdown, all but monitor off
// - thermal shutdown returns to normal at the recovery threshold
// - reduced-slew option for the transceiver applies in normal mode
// - remote wake moves standby to normal and sets the remote-wake flag
// - only the software-set control bit triggers temporary shutdown
// - select falling edge plus transmit high for hold time enters low power
// - select rising edge returns standby to normal as local wake
module lcmc_mode_ctrl (
    // clock and reset
    input wire sys_clk,
    input wire nrst,
    // pins from the host and bus
    input wire mode_sel_pin,
    input wire tx_pin,
    input wire lin_rx_level,
    // analog monitors
    input wire temp_warn,
    input wire overheat_trip_level,
    input wire temp_recovered,
    input wire vbat_undervolt,
    // factory options
    input wire opt_sleep,
    input wire opt_tmpsd_en,
    // software control bits
    input wire tmpsd_req,
    input wire low_slew_req,
    input wire flag_clear,
    // block enables
    output reg ldo_en,
    output reg vcc_pulldown,
    output reg xcvr_en,
    output reg lin_drive_low,
    output reg low_slew_en,
    output reg wake_det_en,
    output reg wwd_en,
    output reg txwd_en,
    output reg divider_en,
    output reg relay_en,
    output reg reset_unit_en,
    output reg pins_pull_low,
    // status
    output reg [2:0] mode,
    output reg heat_warn_flag,
    output reg overheat_flag,
    output reg rwake_flag
);
    localparam ST_OFF = `LCMC_ST_OFF;
    localparam ST_NORMAL = `LCMC_ST_NORMAL;
    localparam ST_STANDBY = `LCMC_ST_STANDBY;
    localparam ST_SLEEP = `LCMC_ST_SLEEP;
    localparam ST_TMPSD = `LCMC_ST_TMPSD;
    localparam ST_THERM = `LCMC_ST_THERM;
    localparam [`LCMC_CNT_W-1:0] HOLD_CYC = `LCMC_ENTRY_HOLD_CYC;
    localparam [`LCMC_CNT_W-1:0] WAKE_CYC = `LCMC_WAKE_CYC;
    localparam [`LCMC_CNT_W-1:0] TSHD_CYC = `LCMC_TSHD_CYC;
    localparam [`LCMC_CNT_W-1:0] CNT_ONE = 22'h000001;

    wire sel_s;
    wire tx_s;
    wire lin_s;
    wire warn_s;
    wire trip_s;
    wire recov_s;
    wire uvbat_s;

    lcmc_sync u_sync_sel (.sys_clk(sys_clk), .nrst(nrst),
        .din(mode_sel_pin), .dout(sel_s));
    lcmc_sync u_sync_tx (.sys_clk(sys_clk), .nrst(nrst),
        .din(tx_pin), .dout(tx_s));
    lcmc_sync u_sync_lin (.sys_clk(sys_clk), .nrst(nrst),
        .din(lin_rx_level), .dout(lin_s));
    lcmc_sync u_sync_warn (.sys_clk(sys_clk), .nrst(nrst),
        .din(temp_warn), .dout(warn_s));
    lcmc_sync u_sync_trip (.sys_clk(sys_clk), .nrst(nrst),
        .din(overheat_trip_level), .dout(trip_s));
    lcmc_sync u_sync_recov (.sys_clk(sys_clk), .nrst(nrst),
        .din(temp_recovered), .dout(recov_s));
    lcmc_sync u_sync_uvbat (.sys_clk(sys_clk), .nrst(nrst),
        .din(vbat_undervolt), .dout(uvbat_s));

    reg [2:0] state;
    reg [2:0] next_state;
    reg sel_d;
    reg tmpsd_req_d;
    reg entry_armed;
    reg [`LCMC_CNT_W-1:0] hold_cnt;
    reg [`LCMC_CNT_W-1:0] wake_cnt;
    reg [`LCMC_CNT_W-1:0] tshd_cnt;

    wire sel_fall = sel_d & ~sel_s;
    wire sel_rise = ~sel_d & sel_s;
    // only a fresh software write counts as a request
    wire tmpsd_set = tmpsd_req & ~tmpsd_req_d;
    wire entry_done = entry_armed & (hold_cnt >= HOLD_CYC);
    wire wake_done = (wake_cnt >= WAKE_CYC);
    wire tshd_done = (tshd_cnt >= TSHD_CYC);

    // edge history and software request history
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sel_d <= 1'b1;
            tmpsd_req_d <= 1'b0;
        end
        else
        begin
            sel_d <= sel_s;
            tmpsd_req_d <= tmpsd_req;
        end
    end

    // low-power entry: select fell, transmit held high
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            entry_armed <= 1'b0;
            hold_cnt <= {`LCMC_CNT_W{1'b0}};
        end
        else if (state != ST_NORMAL || sel_s || !tx_s)
        begin
            entry_armed <= 1'b0;
            hold_cnt <= {`LCMC_CNT_W{1'b0}};
        end
        else if (sel_fall)
        begin
            entry_armed <= 1'b1;
            hold_cnt <= CNT_ONE;
        end
        else if (entry_armed && !entry_done)
        begin
            hold_cnt <= hold_cnt + CNT_ONE;
        end
    end

    // remote wake: bus dominant for the wake time
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            wake_cnt <= {`LCMC_CNT_W{1'b0}};
        else if ((state != ST_STANDBY && state != ST_SLEEP) || lin_s)
            wake_cnt <= {`LCMC_CNT_W{1'b0}};
        else if (!wake_done)
            wake_cnt <= wake_cnt + CNT_ONE;
    end

    // temporary shutdown interval
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            tshd_cnt <= {`LCMC_CNT_W{1'b0}};
        else if (state != ST_TMPSD)
            tshd_cnt <= {`LCMC_CNT_W{1'b0}};
        else if (!tshd_done)
            tshd_cnt <= tshd_cnt + CNT_ONE;
    end

    // mode transitions
    always @*
    begin
        next_state = state;
        case (state)
            ST_OFF:
                next_state = ST_NORMAL;
            ST_NORMAL:
            begin
                if (tmpsd_set && opt_tmpsd_en)
                    next_state = ST_TMPSD;
                else if (entry_done)
                    next_state = opt_sleep ? ST_SLEEP : ST_STANDBY;
            end
            ST_STANDBY:
            begin
                if (tmpsd_set && opt_tmpsd_en)
                    next_state = ST_TMPSD;
                else if (sel_rise)
                    next_state = ST_NORMAL;
                else if (wake_done)
                    next_state = ST_NORMAL;
            end
            ST_SLEEP:
            begin
                if (wake_done)
                    next_state = ST_NORMAL;
            end
            ST_TMPSD:
            begin
                if (tshd_done)
                    next_state = ST_NORMAL;
            end
            ST_THERM:
            begin
                if (recov_s && !trip_s)
                    next_state = ST_NORMAL;
            end
            default:
                next_state = ST_OFF;
        endcase
        if (trip_s && state != ST_OFF)
            next_state = ST_THERM;
        if (uvbat_s)
            next_state = ST_OFF;
    end

    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            state <= ST_OFF;
        else
            state <= next_state;
    end

    // flags: a set in the clearing cycle wins
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            heat_warn_flag <= 1'b0;
            overheat_flag <= 1'b0;
            rwake_flag <= 1'b0;
        end
        else if (uvbat_s)
        begin
            heat_warn_flag <= 1'b0;
            overheat_flag <= 1'b0;
            rwake_flag <= 1'b0;
        end
        else
        begin
            heat_warn_flag <= warn_s | (heat_warn_flag & ~flag_clear);
            overheat_flag <= trip_s | (overheat_flag & ~flag_clear);
            rwake_flag <= (wake_done && state == ST_STANDBY &&
                next_state == ST_NORMAL) | (rwake_flag & ~flag_clear);
        end
    end

    // per-mode block enables, registered from the next mode
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ldo_en <= 1'b0;
            vcc_pulldown <= 1'b1;
            xcvr_en <= 1'b0;
            lin_drive_low <= 1'b0;
            low_slew_en <= 1'b0;
            wake_det_en <= 1'b0;
            wwd_en <= 1'b0;
            txwd_en <= 1'b0;
            divider_en <= 1'b0;
            relay_en <= 1'b0;
            reset_unit_en <= 1'b0;
            pins_pull_low <= 1'b0;
            mode <= ST_OFF;
        end
        else
        begin
            mode <= next_state;
            // normal: everything on except wake detection
            ldo_en <= (next_state == ST_NORMAL) ||
                (next_state == ST_STANDBY);
            vcc_pulldown <= (next_state == ST_SLEEP) ||
                (next_state == ST_TMPSD) || (next_state == ST_THERM) ||
                (next_state == ST_OFF);
            xcvr_en <= (next_state == ST_NORMAL);
            // bus dominant only while transmit is low in normal mode
            lin_drive_low <= (next_state == ST_NORMAL) && !tx_s;
            low_slew_en <= (next_state == ST_NORMAL) && low_slew_req;
            wake_det_en <= (next_state == ST_STANDBY) ||
                (next_state == ST_SLEEP);
            wwd_en <= (next_state == ST_NORMAL);
            txwd_en <= (next_state == ST_NORMAL);
            divider_en <= (next_state == ST_NORMAL);
            relay_en <= (next_state == ST_NORMAL);
            reset_unit_en <= (next_state == ST_NORMAL) ||
                (next_state == ST_STANDBY);
            pins_pull_low <= (next_state == ST_TMPSD);
        end
    end
endmodule

// >>> rtl/lcmc_sync.v
`timescale 1ns/1ps
// two-flop synchroniser for an asynchronous pin
module lcmc_sync (
    // clock and reset
    input wire sys_clk,
    input wire nrst,
    // data
    input wire din,
    output reg dout
);
    reg stage1;

    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// >>> test/lcmc_host.sv
`timescale 1ns/1ps
// host side of select and transmit pins
module lcmc_host (
    // clock
    input logic sys_clk,
    // commands from the bench
    input logic go_low,
    input logic tx_bit,
    // pins
    output logic mode_sel_pin = 1'b1,
    output logic tx_pin = 1'b1
);
    always @(posedge sys_clk)
    begin
        mode_sel_pin <= !go_low;
        tx_pin <= go_low | tx_bit;
    end
endmodule

// >>> test/lcmc_mode_ctrl_chk.sv
`timescale 1ns/1ps
`include "lcmc_defs.vh"
module lcmc_mode_chk (
    // clock and reset
    input logic sys_clk,
    input logic nrst,
    // monitors, straps, control
    input logic vbat_undervolt,
    input logic overheat_trip_level,
    input logic temp_recovered,
    input logic opt_sleep,
    input logic opt_tmpsd_en,
    input logic tmpsd_req,
    // enables and mode
    input logic ldo_en,
    input logic vcc_pulldown,
    input logic xcvr_en,
    input logic wake_det_en,
    input logic wwd_en,
    input logic txwd_en,
    input logic divider_en,
    input logic relay_en,
    input logic reset_unit_en,
    input logic pins_pull_low,
    input logic [2:0] mode
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    property p_boot;
        mode == `LCMC_ST_OFF && !$past(vbat_undervolt, 2)
            |=> mode == `LCMC_ST_NORMAL;
    endproperty
    a_boot: assert property (p_boot) else $error("no normal");
    property p_norm;
        mode == `LCMC_ST_NORMAL |-> ldo_en && xcvr_en && wwd_en
            && !vcc_pulldown && txwd_en && divider_en && relay_en;
    endproperty
    a_norm: assert property (p_norm) else $error("normal en");
    property p_stby;
        mode == `LCMC_ST_STANDBY |-> !opt_sleep && !xcvr_en && !wwd_en
            && wake_det_en && !txwd_en && !divider_en && !relay_en;
    endproperty
    a_stby: assert property (p_stby) else $error("standby en");
    property p_slp;
        mode == `LCMC_ST_SLEEP |-> opt_sleep && !ldo_en && !xcvr_en
            && !reset_unit_en && vcc_pulldown && wake_det_en;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep en");
    property p_tsd;
        mode == `LCMC_ST_TMPSD |-> !ldo_en && vcc_pulldown && !xcvr_en
            && !wake_det_en && pins_pull_low;
    endproperty
    a_tsd: assert property (p_tsd) else $error("tsd en");
    property p_treq;
        $rose(tmpsd_req) && opt_tmpsd_en && !$past(overheat_trip_level, 2)
            && !$past(vbat_undervolt, 2) && (mode == `LCMC_ST_NORMAL
            || mode == `LCMC_ST_STANDBY) |=> mode == `LCMC_ST_TMPSD;
    endproperty
    a_treq: assert property (p_treq) else $error("tsd entry");
    property p_topt;
        !opt_tmpsd_en |-> mode != `LCMC_ST_TMPSD;
    endproperty
    a_topt: assert property (p_topt) else $error("tsd opt");
    property p_hot;
        $past(overheat_trip_level, 2) && !$past(vbat_undervolt, 2)
            && mode != `LCMC_ST_OFF
            |=> mode == `LCMC_ST_THERM && !ldo_en && !xcvr_en
            && !wake_det_en && !wwd_en;
    endproperty
    a_hot: assert property (p_hot) else $error("thermal");
    property p_cool;
        mode == `LCMC_ST_THERM && $past(temp_recovered, 2)
            && !$past(overheat_trip_level, 2) && !$past(vbat_undervolt, 2)
            |=> mode == `LCMC_ST_NORMAL;
    endproperty
    a_cool: assert property (p_cool) else $error("recovery");
    property p_uv;
        $past(vbat_undervolt, 2)
            |=> mode == `LCMC_ST_OFF && !ldo_en && !xcvr_en;
    endproperty
    a_uv: assert property (p_uv) else $error("undervolt");
endmodule

bind lcmc_mode_ctrl lcmc_mode_chk i_chk (.*);

// >>> test/lcmc_mode_ctrl_tb.sv
`timescale 1ns/1ps
`include "lcmc_defs.vh"
module lcmc_mode_ctrl_tb;
    logic sys_clk = 0, nrst = 0, go_low = 0, tx_bit = 1;
    logic lin_rx_level = 1, temp_warn = 0, overheat_trip_level = 0;
    logic temp_recovered = 0, vbat_undervolt = 0, opt_sleep = 0;
    logic opt_tmpsd_en = 0, tmpsd_req = 0, low_slew_req = 0, flag_clear = 0;
    logic mode_sel_pin, tx_pin, ldo_en, vcc_pulldown, xcvr_en, lin_drive_low;
    logic low_slew_en, wake_det_en, wwd_en, txwd_en, divider_en, relay_en;
    logic reset_unit_en, pins_pull_low, heat_warn_flag, overheat_flag;
    logic rwake_flag;
    logic [2:0] mode;
    int n_mismatch = 0, checks = 0, cyc = 0;
    // {sleep strap, wake by bus, mode after wake, remote-wake flag}
    logic [5:0] rows [4] = '{6'h02, 6'h13, 6'h26, 6'h32};
    lcmc_mode_ctrl i_dut (.*);
    lcmc_host i_host (.*);
    always #20 sys_clk = ~sys_clk;
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [2:0] exp, got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic boot(input logic s, t);
        go_low = 0;
        tmpsd_req = 0;
        opt_sleep = s;
        opt_tmpsd_en = t;
        nrst = 0;
        step(20);
        nrst = 1;
        step(4);
        chk("boot mode", `LCMC_ST_NORMAL, mode);
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial
    begin
        foreach (rows[i])
        begin
            boot(rows[i][5], 0);
            go_low = 1;
            step(12);
            chk("lp mode", rows[i][5] ? 3'h3 : 3'h2, mode);
            if (rows[i][4])
            begin
                lin_rx_level = 0;
                step(2600);
                lin_rx_level = 1;
            end
            else
                go_low = 0;
            step(6);
            chk("wake mode", rows[i][3:1], mode);
            chk("rwake", {2'h0, rows[i][0]}, {2'h0, rwake_flag});
        end
        boot(0, 0);
        tx_bit = 0;
        step(5);
        chk("drive", 3'h1, {2'h0, lin_drive_low});
        tx_bit = 1;
        low_slew_req = 1;
        temp_warn = 1;
        tmpsd_req = 1;
        step(5);
        chk("drive", 3'h0, {2'h0, lin_drive_low});
        chk("slew", 3'h1, {2'h0, low_slew_en});
        chk("warn", 3'h1, {2'h0, heat_warn_flag});
        chk("no tsd", `LCMC_ST_NORMAL, mode);
        temp_warn = 0;
        flag_clear = 1;
        step(4);
        chk("warn clr", 3'h0, {2'h0, heat_warn_flag});
        flag_clear = 0;
        boot(0, 1);
        tmpsd_req = 1;
        step(4);
        chk("tsd", `LCMC_ST_TMPSD, mode);
        lin_rx_level = 0;
        step(2600);
        chk("tsd hold", `LCMC_ST_TMPSD, mode);
        chk("pins low", 3'h1, {2'h0, pins_pull_low});
        lin_rx_level = 1;
        overheat_trip_level = 1;
        step(4);
        chk("hot", `LCMC_ST_THERM, mode);
        chk("ot flag", 3'h1, {2'h0, overheat_flag});
        overheat_trip_level = 0;
        step(5);
        chk("hot hold", `LCMC_ST_THERM, mode);
        temp_recovered = 1;
        step(4);
        chk("cool", `LCMC_ST_NORMAL, mode);
        temp_recovered = 0;
        vbat_undervolt = 1;
        step(4);
        chk("uv", `LCMC_ST_OFF, mode);
        chk("uv flag", 3'h0, {2'h0, overheat_flag});
        vbat_undervolt = 0;
        step(4);
        chk("uv end", `LCMC_ST_NORMAL, mode);
        give_verdict();
    end
endmodule
